//--- src/frame_parser.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RQ1] data-link address is thirteen unsigned bits
// [RQ2] addresses up to 8175 mean user ports
// [RQ3] first octet top six bits ones, c/r, extension
// [RQ4] pstn 8176, control 8177
// [RQ5] bearer allocation uses 8178
// [RQ6] protection 8179, link control 8180
// [RQ7] discriminator, two address octets, type
// [RQ8] every message carries four-octet header
// [RQ9] no information element repeated
// [RQ10] bit one sent first in octet
// [RQ11] octet one sent first
// [RQ12] higher octet numbers carry lower significance
// [RQ13] unused bits sent as zero
// [RQ14] nonzero reserved bits are not errors
// [RQ15] protection on primary and secondary links
// [RQ16] bearer allocation on its own link
// [RQ17] discriminator value 01001000 only
// [RQ18] type bit 8 clear selects sub-protocol
// [RQ19] short messages dropped as malformed
module frame_parser #(
   parameter int FIFO_DEPTH = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // link
   access_link_if.receiver link,
   // decoded header
   output logic hdr_valid_r,
   output logic [12:0] dla_r,
   output logic cmd_resp_r,
   output logic [15:0] l3_address_r,
   output logic [7:0] msg_type_r,
   output logic [2:0] subproto_r,
   output logic from_secondary_r,
   // body octets to layer 3
   output logic [7:0] body_data_r,
   output logic body_valid_r,
   output logic body_last_r,
   input wire logic body_ready,
   // errors
   output logic drop_r,
   output logic [2:0] drop_cause_r
);
   // only queue depths 8 and 16 are allowed
   if (FIFO_DEPTH != 8 && FIFO_DEPTH != 16) begin : g_depth_check
      $error("unsupported depth");
   end
   typedef enum logic [3:0] {
      P_ADDR = 4'h1,
      P_HDR = 4'h2,
      P_BODY = 4'h4,
      P_SKIP = 4'h8
   } pstate_t;
   pstate_t state_r;
   logic [2:0] idx_r;
   logic [7:0] a1_r;
   logic [7:0] hdr_r [3];
   logic [9:0] f_in;
   logic f_in_valid;
   logic f_in_ready;
   logic [9:0] f_out;
   logic f_out_valid;
   logic f_out_ready;
   logic take;
   logic [12:0] dla_w;
   logic [2:0] cls;

   // body octets queue through a fifo, ready back-pressures the link
   octet_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) body_q (
      .clock(clock),
      .rstn(rstn),
      .in_data(f_in),
      .in_valid(f_in_valid),
      .in_ready(f_in_ready),
      .out_data(f_out),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready)
   );
   assign link.ready = f_in_ready;
   assign take = link.valid && f_in_ready;
   // bit 0 arrived first; octet order rebuilds fields msb first
   assign dla_w = {a1_r[7:2], link.data[7:1]}; // RQ1 RQ10 RQ11 RQ12
   assign cls = 3'(framer_pkg::type_class(link.data));
   assign f_in_valid = take && state_r == P_BODY;
   assign f_in = {1'b0, link.last, link.data};
   assign f_out_ready = !body_valid_r || body_ready;

   // fifo drain into registered body outputs
   always_ff @(posedge clock) begin
      if (!rstn) begin
         body_valid_r <= 1'b0;
         body_data_r <= 8'h00;
         body_last_r <= 1'b0;
      end else if (f_out_ready) begin
         body_valid_r <= f_out_valid;
         body_data_r <= f_out[7:0];
         body_last_r <= f_out[8];
      end
   end

   // header walk; frames start in address state
   always_ff @(posedge clock) begin
      if (!rstn) begin
         state_r <= P_ADDR;
         idx_r <= 3'h0;
         a1_r <= 8'h00;
         hdr_r <= '{default: 8'h00};
         drop_r <= 1'b0;
         drop_cause_r <= 3'h0;
         hdr_valid_r <= 1'b0;
         dla_r <= 13'h0;
         cmd_resp_r <= 1'b0;
         l3_address_r <= 16'h0;
         msg_type_r <= 8'h00;
         subproto_r <= 3'h0;
         from_secondary_r <= 1'b0;
      end else begin
         drop_r <= 1'b0;
         hdr_valid_r <= 1'b0;
         if (take) begin
            case (state_r)
               P_ADDR: begin
                  idx_r <= idx_r + 3'h1;
                  if (idx_r == 3'h0) begin
                     a1_r <= link.data;
                     if (link.data[7:2] != framer_pkg::OCT1_ONES) begin
                        drop_cause_r <= 3'h1; // RQ3
                        state_r <= P_SKIP;
                     end
                  end else begin
                     idx_r <= 3'h0;
                     dla_r <= dla_w;
                     if (dla_w <= framer_pkg::USER_PORT_MAX ||
                         dla_w > framer_pkg::ADDR_LINK) begin
                        drop_cause_r <= 3'h2; // RQ2 RQ4 RQ5 RQ6
                        state_r <= P_SKIP;
                     end else begin
                        state_r <= P_HDR;
                     end
                  end
                  if (link.last) begin
                     drop_cause_r <= 3'h3; // RQ19
                     state_r <= P_ADDR;
                     idx_r <= 3'h0;
                  end
               end
               P_HDR: begin
                  hdr_r[idx_r[1:0]] <= link.data;
                  idx_r <= idx_r + 3'h1;
                  if (idx_r == 3'h0 && link.data != framer_pkg::DISCRIMINATOR) begin
                     drop_cause_r <= 3'h4; // RQ17
                     state_r <= P_SKIP;
                  end else if (idx_r == 3'h3) begin
                     // only bit 8 and sub-protocol bits checked
                     if (cls != dla_r[2:0] - 3'h0 ||
                         cls == 3'(framer_pkg::SP_BAD)) begin
                        drop_cause_r <= 3'h5; // RQ18 RQ16 RQ14
                        state_r <= P_SKIP;
                     end else begin
                        hdr_valid_r <= 1'b1; // RQ7 RQ8
                        cmd_resp_r <= a1_r[1];
                        l3_address_r <= {hdr_r[1], hdr_r[2]}; // RQ12
                        msg_type_r <= link.data;
                        subproto_r <= cls;
                        from_secondary_r <= link.link_sel; // RQ15
                        state_r <= P_BODY;
                     end
                  end
                  if (link.last) begin
                     idx_r <= 3'h0;
                     state_r <= P_ADDR;
                     if (idx_r != 3'h3) drop_cause_r <= 3'h3; // RQ19
                  end
               end
               default: if (link.last) begin
                  idx_r <= 3'h0;
                  state_r <= P_ADDR;
               end
            endcase
            // short or bad frames flagged once, at their end or on error
            if (state_r != P_SKIP && state_r != P_BODY &&
                (drop_cause_w(state_r, idx_r) ||
                 (link.last && !(state_r == P_HDR && idx_r == 3'h3))))
               drop_r <= 1'b1; // RQ19
         end
      end
   end

   // detects header faults in the octet being taken
   function automatic logic drop_cause_w(input pstate_t s, input logic [2:0] i);
      drop_cause_w = 1'b0;
      case (s)
         P_ADDR: drop_cause_w = (i == 3'h0)
            ? (link.data[7:2] != framer_pkg::OCT1_ONES)
            : (dla_w <= framer_pkg::USER_PORT_MAX ||
               dla_w > framer_pkg::ADDR_LINK);
         P_HDR: drop_cause_w = (i == 3'h0)
            ? (link.data != framer_pkg::DISCRIMINATOR)
            : (i == 3'h3 && (cls != dla_r[2:0] ||
               cls == 3'(framer_pkg::SP_BAD)));
         default: drop_cause_w = 1'b0;
      endcase
   endfunction : drop_cause_w
endmodule : frame_parser
`default_nettype wire

//--- pkg/framer_pkg.sv
`default_nettype none
package framer_pkg;
   // data-link address width and code points
   localparam int ADDR_W = 13;
   localparam logic [12:0] USER_PORT_MAX = 13'h1fef; // 8175
   localparam logic [12:0] ADDR_PSTN = 13'h1ff0; // 8176
   localparam logic [12:0] ADDR_CTRL = 13'h1ff1; // 8177
   localparam logic [12:0] ADDR_BEARER = 13'h1ff2; // 8178
   localparam logic [12:0] ADDR_PROT = 13'h1ff3; // 8179
   localparam logic [12:0] ADDR_LINK = 13'h1ff4; // 8180
   // first address octet: bits 8..3 all ones
   localparam logic [5:0] OCT1_ONES = 6'h3f;
   // protocol discriminator and header length in octets
   localparam logic [7:0] DISCRIMINATOR = 8'h48;
   localparam int HDR_LEN = 4;
   // sub-protocol selector
   typedef enum logic [2:0] {
      SP_PSTN = 3'h0,
      SP_CTRL = 3'h1,
      SP_BEARER = 3'h2,
      SP_PROT = 3'h3,
      SP_LINK = 3'h4,
      SP_BAD = 3'h7
   } subproto_t;

   // data-link address for a sub-protocol
   function automatic logic [12:0] addr_of(input subproto_t sp);
      case (sp)
         SP_PSTN: addr_of = ADDR_PSTN;
         SP_CTRL: addr_of = ADDR_CTRL;
         SP_BEARER: addr_of = ADDR_BEARER;
         SP_PROT: addr_of = ADDR_PROT;
         SP_LINK: addr_of = ADDR_LINK;
         default: addr_of = ADDR_PSTN;
      endcase
   endfunction : addr_of

   // sub-protocol implied by message type bits 8..4
   function automatic subproto_t type_class(input logic [7:0] mt);
      if (mt[7]) type_class = SP_BAD;
      else if (mt[6:4] == 3'h0) type_class = SP_PSTN;
      else if (mt[6:3] == 4'h2) type_class = SP_CTRL;
      else if (mt[6:3] == 4'h3) type_class = SP_PROT;
      else if (mt[6:4] == 3'h2) type_class = SP_BEARER;
      else if (mt[6:3] == 4'h6) type_class = SP_LINK;
      else type_class = SP_BAD;
   endfunction : type_class
endpackage : framer_pkg
`default_nettype wire

//--- pkg/access_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface access_link_if;
   // one octet per beat, bit 0 is transmitted bit 1
   logic [7:0] data;
   logic valid;
   logic last;
   logic ready;
   logic link_sel; // 0 primary link, 1 secondary link
   modport sender (output data, valid, last, link_sel, input ready);
   modport receiver (input data, valid, last, link_sel, output ready);
endinterface : access_link_if
`default_nettype wire

//--- src/octet_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module octet_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   // refuse depths the pointer arithmetic cannot serve
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
      $error("depth must be power of 2");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_r;
   logic [AW:0] rd_r;
   logic push;
   logic pop;

   // flags from pointer compare
   assign in_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
   assign out_valid = wr_r != rd_r;
   assign out_data = mem[rd_r[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage
   always_ff @(posedge clock) begin
      if (push) mem[wr_r[AW-1:0]] <= in_data;
   end

   // pointers
   always_ff @(posedge clock) begin
      if (!rstn) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (push) wr_r <= wr_r + 1'b1;
         if (pop) rd_r <= rd_r + 1'b1;
      end
   end
endmodule : octet_fifo
`default_nettype wire

//--- src/frame_builder.sv
`timescale 1ns/1ps
`default_nettype none
module frame_builder (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // user request
   input wire logic start,
   input wire logic [2:0] subproto,
   input wire logic cmd_resp,
   input wire logic [15:0] l3_address,
   input wire logic [7:0] msg_type,
   input wire logic [7:0] body_len,
   output logic busy_r,
   output logic rejected_r,
   // body octets
   input wire logic [7:0] body_data,
   input wire logic body_valid,
   output logic body_ready_r,
   // link
   access_link_if.sender link
);
   typedef enum logic [4:0] {
      B_IDLE = 5'h01,
      B_ADDR = 5'h02,
      B_HDR = 5'h04,
      B_BODY = 5'h08,
      B_DONE = 5'h10
   } bstate_t;
   bstate_t state_r;
   logic [2:0] idx_r;
   logic [7:0] left_r;
   logic [12:0] dla_r;
   logic cr_r;
   logic [15:0] l3_r;
   logic [7:0] mt_r;
   logic [7:0] oct;
   logic sending;
   logic is_last;
   logic refuse;
   logic alt_r;

   // octet to put on the link
   always_comb begin
      oct = 8'h00;
      case (state_r)
         // bits 8..3 ones, then c/r, extension 0
         B_ADDR: oct = (idx_r == 3'h0) ? {dla_r[12:7], cr_r, 1'b0} // RQ3 RQ1
                                     : {dla_r[6:0], 1'b1}; // RQ4 RQ5 RQ6
         // discriminator, address high, low, type
         B_HDR: case (idx_r)
            3'h0: oct = framer_pkg::DISCRIMINATOR; // RQ17 RQ7
            3'h1: oct = l3_r[15:8]; // RQ12
            3'h2: oct = l3_r[7:0];
            default: oct = {1'b0, mt_r[6:0]}; // RQ18 RQ13
         endcase
         B_BODY: oct = body_data;
         default: oct = 8'h00;
      endcase
   end
   // request whose type class does not fit its sub-protocol
   assign refuse = framer_pkg::type_class(msg_type) !=
                   framer_pkg::subproto_t'(subproto) || subproto > 3'h4;
   assign sending = link.valid && link.ready;
   assign is_last = (state_r == B_HDR && idx_r == 3'h3 && left_r == 8'h00)
                 || (state_r == B_BODY && left_r == 8'h01);

   // link outputs, bit 0 leaves first
   always_ff @(posedge clock) begin
      if (!rstn) begin
         link.valid <= 1'b0;
         link.data <= 8'h00;
         link.last <= 1'b0;
      end else if (!link.valid || link.ready) begin
         link.valid <= (state_r == B_ADDR || state_r == B_HDR ||
                        (state_r == B_BODY && body_valid)) && !sending; // RQ10 RQ11
         link.data <= oct;
         link.last <= is_last;
      end
   end
   // accepted protection frames alternate links, first on primary
   always_ff @(posedge clock) begin
      if (!rstn) begin
         link.link_sel <= 1'b0;
         alt_r <= 1'b0;
      end else if (start && state_r == B_IDLE && !refuse &&
                   subproto == 3'(framer_pkg::SP_PROT)) begin
         link.link_sel <= alt_r; // RQ15 RQ16
         alt_r <= ~alt_r;
      end
   end

   // sequencing
   always_ff @(posedge clock) begin
      if (!rstn) begin
         state_r <= B_IDLE;
         idx_r <= 3'h0;
         left_r <= 8'h00;
         dla_r <= 13'h0;
         cr_r <= 1'b0;
         l3_r <= 16'h0;
         mt_r <= 8'h00;
         rejected_r <= 1'b0;
      end else begin
         rejected_r <= 1'b0;
         case (state_r)
            B_IDLE: if (start) begin
               if (refuse) begin
                  rejected_r <= 1'b1; // RQ2 RQ18
               end else begin
                  dla_r <= framer_pkg::addr_of(framer_pkg::subproto_t'(subproto));
                  cr_r <= cmd_resp;
                  l3_r <= l3_address;
                  mt_r <= msg_type;
                  left_r <= body_len;
                  idx_r <= 3'h0;
                  state_r <= B_ADDR;
               end
            end
            B_ADDR: if (sending) begin
               idx_r <= idx_r + 3'h1;
               if (idx_r == 3'h1) begin
                  idx_r <= 3'h0;
                  state_r <= B_HDR; // RQ8
               end
            end
            B_HDR: if (sending) begin
               idx_r <= idx_r + 3'h1;
               if (idx_r == 3'h3)
                  state_r <= (left_r == 8'h00) ? B_DONE : B_BODY; // RQ9
            end
            B_BODY: if (sending) begin
               left_r <= left_r - 8'h01;
               if (left_r == 8'h01) state_r <= B_DONE;
            end
            default: state_r <= B_IDLE;
         endcase
      end
   end
   // status and body handshake
   always_ff @(posedge clock) begin
      if (!rstn) begin
         busy_r <= 1'b0;
         body_ready_r <= 1'b0;
      end else begin
         busy_r <= state_r != B_IDLE;
         body_ready_r <= state_r == B_BODY && link.ready && link.valid;
      end
   end
endmodule : frame_builder
`default_nettype wire

//--- tb/framer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module framer_properties (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // link
   input wire logic [7:0] data,
   input wire logic valid,
   input wire logic last,
   input wire logic ready,
   input wire logic link_sel
);
   logic take;
   logic [3:0] idx_r;
   logic [2:0] code_r;
   logic sel_r;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   assign take = valid && ready;
   // octet position on the wire, saturating
   always_ff @(posedge clock) begin
      if (!rstn) idx_r <= 4'h0;
      else if (take && last) idx_r <= 4'h0;
      else if (take && idx_r != 4'hf) idx_r <= idx_r + 4'h1;
   end
   // entity code of the current frame
   always_ff @(posedge clock) begin
      if (!rstn) code_r <= 3'h0;
      else if (take && idx_r == 4'h1) code_r <= data[3:1];
   end
   // link used by the previous protection frame
   always_ff @(posedge clock) begin
      if (!rstn) sel_r <= 1'b1;
      else if (take && idx_r == 4'h1 && data[3:1] == 3'h3) sel_r <= link_sel;
   end
   // type octet pattern for an entity code
   function automatic logic class_ok(input logic [2:0] c, input logic [7:0] m);
      case (c)
         3'h0: class_ok = m[6:4] == 3'h0;
         3'h1: class_ok = m[6:3] == 4'h2;
         3'h2: class_ok = m[6:4] == 3'h2;
         3'h3: class_ok = m[6:3] == 4'h3;
         3'h4: class_ok = m[6:3] == 4'h6;
         default: class_ok = 1'b0;
      endcase
   endfunction : class_ok
   sequence s_stall;
      valid && !ready;
   endsequence
   sequence s_held;
      valid && $stable(data) && $stable(last) && $stable(link_sel);
   endsequence
   a_hold_on_stall: assert property (s_stall |=> s_held)
      else $error("link octet changed while stalled");
   a_first_octet: assert property (take && idx_r == 4'h0 |->
      data[7:2] == 6'h3f && !data[0]) else $error("bad first octet");
   a_entity_addr: assert property (take && idx_r == 4'h1 |->
      data[7:4] == 4'he && data[3:1] <= 3'h4 && data[0])
      else $error("bad second octet");
   a_discrim_value: assert property (take && idx_r == 4'h2 |->
      data == 8'h48) else $error("bad discriminator");
   a_type_bit8: assert property (take && idx_r == 4'h5 |-> !data[7])
      else $error("type bit 8 set");
   a_type_matches_addr: assert property (take && idx_r == 4'h5 |->
      class_ok(code_r, data)) else $error("type class differs from address");
   a_header_complete: assert property (take && last |-> idx_r >= 4'h5)
      else $error("frame ended inside header");
   a_prot_alternate: assert property
      (take && idx_r == 4'h1 && data[3:1] == 3'h3 |-> link_sel != sel_r)
      else $error("protection link did not alternate");
endmodule : framer_properties
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic start = 1'b0;
   logic [2:0] subproto = 3'h0;
   logic cmd_resp = 1'b0;
   logic [15:0] l3_address = 16'h0000;
   logic [7:0] msg_type = 8'h00;
   logic [7:0] body_len = 8'h00;
   logic [7:0] body_data = 8'h00;
   logic body_valid = 1'b0;
   logic body_ready = 1'b1;
   logic hold_low = 1'b0;
   logic exp_sec = 1'b0;
   logic busy_r, rejected_r, body_ready_r, hdr_valid_r, cmd_resp_r;
   logic from_secondary_r, body_valid_r, body_last_r, drop_r, b_hdr, b_drop;
   logic [12:0] dla_r;
   logic [15:0] l3_address_r;
   logic [7:0] msg_type_r, body_data_r;
   logic [2:0] subproto_r, drop_cause_r, b_cause, last_cause;
   logic [27:0] hx;
   logic [23:0] wx;
   logic [8:0] bx;
   logic [27:0] hq[$];
   logic [23:0] wq[$];
   logic [8:0] bq[$];
   logic [7:0] wb[$];
   int failures = 0;
   int comparisons = 0;
   int seed = 32'hc6ed;
   int b_hdr_n = 0;
   int b_drop_n = 0;
   int k, r;
   access_link_if link_a ();
   access_link_if link_b ();
   frame_builder i_frame_builder (.clock(clock), .rstn(rstn), .start(start),
      .subproto(subproto), .cmd_resp(cmd_resp), .l3_address(l3_address),
      .msg_type(msg_type), .body_len(body_len), .busy_r(busy_r),
      .rejected_r(rejected_r), .body_data(body_data),
      .body_valid(body_valid), .body_ready_r(body_ready_r),
      .link(link_a.sender));
   frame_parser #(.FIFO_DEPTH(8)) i_frame_parser (.clock(clock), .rstn(rstn),
      .link(link_a.receiver), .hdr_valid_r(hdr_valid_r), .dla_r(dla_r),
      .cmd_resp_r(cmd_resp_r), .l3_address_r(l3_address_r),
      .msg_type_r(msg_type_r), .subproto_r(subproto_r),
      .from_secondary_r(from_secondary_r), .body_data_r(body_data_r),
      .body_valid_r(body_valid_r), .body_last_r(body_last_r),
      .body_ready(body_ready), .drop_r(drop_r), .drop_cause_r(drop_cause_r));
   frame_parser #(.FIFO_DEPTH(8)) i_frame_parser_b (.clock(clock),
      .rstn(rstn), .link(link_b.receiver), .hdr_valid_r(b_hdr), .dla_r(),
      .cmd_resp_r(), .l3_address_r(), .msg_type_r(), .subproto_r(),
      .from_secondary_r(), .body_data_r(), .body_valid_r(), .body_last_r(),
      .body_ready(1'b1), .drop_r(b_drop), .drop_cause_r(b_cause));
   framer_properties i_framer_properties (.clock(clock), .rstn(rstn),
      .data(link_a.data), .valid(link_a.valid), .last(link_a.last),
      .ready(link_a.ready), .link_sel(link_a.link_sel));
   // 250 MHz clock
   always #2 clock = ~clock;
   task automatic check(input string name, input logic [27:0] e,
                        input logic [27:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, e, g);
      end
   endtask : check
   task automatic give_verdict();
      if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   // type octet of a given sub-protocol class
   function automatic logic [7:0] mt_for(input logic [2:0] c,
                                         input logic [7:0] v);
      case (c)
         3'h0: mt_for = {4'h0, v[3:0]};
         3'h1: mt_for = {5'h02, v[2:0]};
         3'h2: mt_for = {4'h2, v[3:0]};
         3'h3: mt_for = {5'h03, v[2:0]};
         default: mt_for = {5'h06, v[2:0]};
      endcase
   endfunction : mt_for
   // random or stalled consumer of parser body
   always @(negedge clock) body_ready <= !hold_low && ($random(seed) % 4 != 0);
   // watch parser outputs and the wire
   always @(posedge clock) begin
      if (rstn && hdr_valid_r) begin
         hx = hq.pop_front();
         check("header", hx, {cmd_resp_r, subproto_r, l3_address_r,
            msg_type_r});
         check("dla", {15'h0, 13'h1ff0 + 13'(hx[26:24])}, {15'h0, dla_r});
         if (hx[26:24] == 3'h3) begin
            check("secondary", {27'h0, exp_sec}, {27'h0, from_secondary_r});
            exp_sec = ~exp_sec;
         end
      end
      if (rstn && body_valid_r && body_ready) begin
         bx = bq.pop_front();
         check("body", {19'h0, bx}, {19'h0, body_last_r, body_data_r});
      end
      if (rstn && drop_r) check("drop", 28'h0, {25'h0, drop_cause_r});
      if (rstn && link_a.valid && link_a.ready) begin
         wb.push_back(link_a.data);
         if (link_a.last) begin
            wx = wq.pop_front();
            check("wire_len", {20'h0, wx[23:16] + 8'h6},
               28'(wb.size()));
            check("wire_hdr", {4'h0, 8'h48, wx[15:0]},
               {4'h0, wb[2], wb[3], wb[4]});
            wb.delete();
         end
      end
      if (rstn && b_hdr) b_hdr_n++;
      if (rstn && b_drop) begin
         b_drop_n++;
         last_cause = b_cause;
      end
   end
   task automatic send_frame(input logic [2:0] sp, input logic [7:0] mt,
                             input logic [7:0] len, input logic bad);
      logic [7:0] bb[$];
      logic rj;
      int i, n;
      for (i = 0; i < len; i++) bb.push_back(8'($random(seed)));
      @(negedge clock);
      subproto = sp;
      msg_type = mt;
      body_len = len;
      l3_address = 16'($random(seed));
      cmd_resp = 1'($random(seed));
      body_data = (len > 0) ? bb[0] : 8'h00;
      body_valid = 1'b1;
      start = 1'b1;
      if (!bad) hq.push_back({cmd_resp, sp, l3_address, mt});
      if (!bad) wq.push_back({len, l3_address});
      for (i = 0; i < len && !bad; i++) bq.push_back({i == len - 1, bb[i]});
      @(negedge clock);
      start = 1'b0;
      rj = rejected_r;
      i = 0;
      n = 0;
      while ((busy_r || n == 0) && n < 500) begin
         @(negedge clock);
         rj = rj | rejected_r;
         if (body_ready_r) i++;
         if (i < len) body_data = bb[i];
         n++;
      end
      body_valid = 1'b0;
      check("rejected", {27'h0, bad}, {27'h0, rj});
      check("consumed", bad ? 28'h0 : 28'(len), 28'(i));
      if (n >= 500) begin
         failures++;
         give_verdict();
      end
   endtask : send_frame
   task automatic raw_case(input logic [7:0] b[$], input logic [2:0] cause);
      int d0, h0, n;
      d0 = b_drop_n;
      h0 = b_hdr_n;
      foreach (b[j]) begin
         @(negedge clock);
         link_b.data = b[j];
         link_b.valid = 1'b1;
         link_b.last = (j == b.size() - 1);
         for (n = 0; !link_b.ready && n < 100; n++) @(negedge clock);
         if (n >= 100) begin
            failures++;
            give_verdict();
         end
      end
      @(negedge clock);
      link_b.valid = 1'b0;
      link_b.data = ~link_b.data;
      repeat (20) @(negedge clock);
      check("raw_drops", {27'h0, cause != 3'h0}, 28'(b_drop_n - d0));
      check("raw_hdr", {27'h0, cause == 3'h0}, 28'(b_hdr_n - h0));
      if (cause != 3'h0)
         check("raw_cause", {25'h0, cause}, {25'h0, last_cause});
   endtask : raw_case
   initial begin
      link_b.data = 8'h00;
      link_b.valid = 1'b0;
      link_b.last = 1'b0;
      link_b.link_sel = 1'b0;
      repeat (8) @(posedge clock);
      @(negedge clock);
      rstn = 1'b1;
      send_frame(3'h3, 8'h18, 8'h0, 1'b0);
      send_frame(3'h3, 8'h1f, 8'h1, 1'b0);
      for (k = 0; k < 5; k++) send_frame(3'(k), mt_for(3'(k), 8'(k)), 8'h3, 1'b0);
      send_frame(3'h5, 8'h10, 8'h2, 1'b1);
      send_frame(3'h0, 8'h30, 8'h2, 1'b1);
      for (k = 0; k < 20; k++) begin
         r = $random(seed);
         send_frame(3'({r} % 5), mt_for(3'({r} % 5), r[15:8]),
            8'(r[23:16] % 13), 1'b0);
      end
      fork
         send_frame(3'h2, 8'h21, 8'h14, 1'b0);
         begin
            hold_low = 1'b1;
            repeat (80) @(negedge clock);
            check("fifo_full", 28'h0, {27'h0, link_a.ready});
            hold_low = 1'b0;
         end
      join
      raw_case('{8'hfc, 8'he3, 8'h48, 8'h12}, 3'h3);
      raw_case('{8'hf8, 8'he3, 8'h48, 8'h12, 8'h34, 8'h10}, 3'h1);
      raw_case('{8'hfc, 8'hef, 8'h48, 8'h12, 8'h34, 8'h10}, 3'h2);
      raw_case('{8'hfc, 8'he3, 8'h49, 8'h12, 8'h34, 8'h10}, 3'h4);
      raw_case('{8'hfc, 8'he3, 8'h48, 8'h12, 8'h34, 8'h30}, 3'h5);
      raw_case('{8'hfe, 8'he7, 8'h48, 8'h00, 8'h01, 8'h18, 8'hff}, 3'h0);
      for (k = 0; k < 400 && (hq.size() + bq.size()) != 0; k++) begin
         @(negedge clock);
      end
      check("drained", 28'h0, 28'(hq.size() + bq.size()));
      give_verdict();
   end
endmodule : tb
`default_nettype wire
